/* File: rtl/level_sync.sv */
/*
 * Chain of flip-flops that brings an asynchronous level into clk.
 * Assumes only the final stage is read by the user.
 */
`timescale 1ns/1ps
`include "thermal_trip_cfg.svh"

module level_sync #(
	parameter int STAGES = `SYNC_STAGES
) (
	// clock
	input  wire logic clk,
	// asynchronous level in, synchronised level out
	input  wire logic d,
	output logic      q
);

	logic [STAGES-1:0] chain;

	if (STAGES < 2) begin
		$error("level_sync needs at least two stages");
	end

	// no reset: the level must survive processor reset
	always_ff @(posedge clk) begin
		chain <= {chain[STAGES-2:0], d};
	end

	assign q = chain[STAGES-1];

endmodule

/* File: rtl/thermal_trip_cfg.svh */
/*
 * Constants of the thermal trip latch: trip level, clock rate, rail
 * shutdown window and synchroniser depth.
 * Assumes nothing; included by bare name where needed.
 */
`ifndef THERMAL_TRIP_CFG_SVH
`define THERMAL_TRIP_CFG_SVH

// nominal junction trip level of the sensor, in degrees C
`define TRIP_TEMP_C      135
// core clock rate in Hz (25 ns period)
`define CLK_FREQ_HZ      40000000
// window for both rails to reach half nominal, in seconds
`define RAIL_OFF_TIME_S  5
// same window in core clock cycles (exact product, no rounding)
`define RAIL_OFF_CYCLES  (`RAIL_OFF_TIME_S * `CLK_FREQ_HZ)
// width of the rail window counter
`define RAIL_CNT_W       28
// stages in the over-temperature synchroniser
`define SYNC_STAGES      2

`endif

/* File: rtl/thermal_trip_latch.sv */
/*
 * Over-temperature trip latch: halts execution until a cool reset and drives the
 * active-low trip output until a cool reset or removal of both rails.
 * Assumes the sensor flag is asynchronous, the rail status inputs are
 * synchronous to clk and rst is the processor reset.
 */
// Operation
// RQ1: over-temperature halts execution, asserts trip output
// RQ2: trip and halt stay latched until reset
// RQ3: reset when cool clears trip, resumes execution
// RQ4: reset while hot keeps trip and halt
// RQ5: system removes both rails within five seconds
// RQ6: both rails off deasserts trip output
// RQ7: system prevents unsafe re-powering after trip release
// RQ8: sensor flag passes two-stage synchroniser first
`timescale 1ns/1ps
`include "thermal_trip_cfg.svh"

module thermal_trip_latch
	import thermal_trip_pkg::*;
#(
	parameter int RAIL_OFF_CYCLES = `RAIL_OFF_CYCLES,
	parameter int CNT_W           = `RAIL_CNT_W
) (
	// clock and reset
	input  wire logic   clk,
	input  wire logic   rst,
	// thermal sensor
	input  wire logic   over_temp,
	// system power logic
	input  rail_status_s rails,
	// outputs to core and system
	output logic         thermal_trip_n,
	output logic         exec_halt,
	output trip_status_s status
);

	trip_state_e            state;
	trip_state_e            next_state;
	logic                   hot;
	logic                   rails_down;
	logic [CNT_W-1:0]       rail_timer;
	logic                   next_late;
	logic                   late_flag;
	logic                   released;

	localparam logic [CNT_W-1:0] TIMER_END =
		CNT_W'(RAIL_OFF_CYCLES - 1);

	// refuse settings the rail counter cannot serve
	if (RAIL_OFF_CYCLES < 1) begin
		$error("rail window must be at least one cycle");
	end
	if (CNT_W < 2 || CNT_W > 31) begin
		$error("rail counter width out of range");
	end
	if (CNT_W < 31 && RAIL_OFF_CYCLES > (1 << CNT_W)) begin
		$error("rail window does not fit the counter");
	end

	// sensor flag into the clk domain
	level_sync #(
		.STAGES(`SYNC_STAGES)
	) u_sync (
		.clk(clk),
		.d  (over_temp), // RQ8
		.q  (hot)
	);

	assign rails_down = rails.core_off & rails.termination_off;

	// next state; reset itself samples the temperature
	always_comb begin
		next_state = state;
		if (rst) begin
			if (hot)
				next_state = TRIPPED; // RQ4
			else
				next_state = RUN; // RQ3
		end else begin
			case (state)
			RUN: begin
				if (hot)
					next_state = TRIPPED; // RQ1
			end
			TRIPPED: begin
				if (rails_down)
					next_state = RAILS_OFF; // RQ6
				else
					next_state = TRIPPED; // RQ2
			end
			RAILS_OFF: begin
				// stays halted; only reset leaves
				next_state = RAILS_OFF; // RQ2
			end
			default: begin
				next_state = RUN;
			end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		state <= next_state;
	end

	// pin and halt registered from the next state
	always_ff @(posedge clk) begin
		thermal_trip_n <= (next_state != TRIPPED); // RQ1 RQ6
		exec_halt      <= (next_state != RUN); // RQ1 RQ2
	end

	// watch the rail window while the trip is driven
	assign next_late = (state == TRIPPED) && !rails_down &&
		(rail_timer == TIMER_END);

	// saturates so the late flag cannot wrap round
	always_ff @(posedge clk) begin
		if (rst || state != TRIPPED)
			rail_timer <= '0;
		else if (rail_timer != TIMER_END)
			rail_timer <= rail_timer + CNT_W'(1); // RQ5
	end

	always_ff @(posedge clk) begin
		if (rst)
			late_flag <= 1'b0;
		else if (next_late)
			late_flag <= 1'b1; // RQ5
	end

	always_ff @(posedge clk) begin
		released <= (next_state == RAILS_OFF); // RQ6
	end

	// both status bits come straight from their flip-flops
	assign status = '{rails_late: late_flag, rails_off: released};

	// checks

	a_sync_hot: assert property (@(posedge clk) // RQ8
		over_temp |-> ##2 hot)
		else $error("sensor flag not seen two cycles later");

	a_sync_cool: assert property (@(posedge clk) // RQ8
		!over_temp |-> ##2 !hot)
		else $error("sensor release not seen two cycles later");

	a_trip_entry: assert property (@(posedge clk) // RQ1
		disable iff (rst)
		hot && state == RUN |=> !thermal_trip_n && exec_halt)
		else $error("hot sensor did not trip and halt");

	a_trip_latched: assert property (@(posedge clk) // RQ2
		disable iff (rst)
		!thermal_trip_n && !rails_down |=> !thermal_trip_n && exec_halt)
		else $error("trip released without reset or rails");

	a_reset_cool: assert property (@(posedge clk) // RQ3
		rst && !hot |=> thermal_trip_n && !exec_halt)
		else $error("cool reset did not clear trip");

	a_reset_hot: assert property (@(posedge clk) // RQ4
		rst && hot |=> !thermal_trip_n && exec_halt)
		else $error("hot reset released trip");

	a_rails_release: assert property (@(posedge clk) // RQ6
		disable iff (rst)
		state == TRIPPED && rails_down |=>
			thermal_trip_n && exec_halt && status.rails_off)
		else $error("trip not released after both rails off");

	a_halt_sticky: assert property (@(posedge clk) // RQ2
		disable iff (rst)
		exec_halt |=> exec_halt)
		else $error("halt dropped without reset");

	a_trip_halts: assert property (@(posedge clk) // RQ1
		disable iff (rst)
		!thermal_trip_n |-> exec_halt)
		else $error("trip driven while executing");

	a_late_flag: assert property (@(posedge clk) // RQ5
		disable iff (rst)
		status.rails_late |-> ##1 status.rails_late)
		else $error("rail late flag dropped without reset");

	a_released_hold: assert property (@(posedge clk) // RQ6
		disable iff (rst)
		state == RAILS_OFF |=>
			thermal_trip_n && exec_halt && status.rails_off)
		else $error("released trip returned or halt dropped");

	a_cool_stays: assert property (@(posedge clk) // RQ3
		disable iff (rst)
		state == RUN && !hot |=> thermal_trip_n && !exec_halt)
		else $error("cool core stopped without cause");

	a_late_cleared: assert property (@(posedge clk) // RQ5
		rst |=> !status.rails_late)
		else $error("rail late flag survived reset");

	a_late_window: assert property (@(posedge clk) // RQ5
		disable iff (rst)
		state != TRIPPED && !status.rails_late |=> !status.rails_late)
		else $error("rail late flag set with no trip driven");

	c_rails_late: cover property (@(posedge clk) disable iff (rst)
		!status.rails_late ##1 status.rails_late);

	c_trip: cover property (@(posedge clk) disable iff (rst)
		state == RUN ##1 state == TRIPPED);

	c_rails_off: cover property (@(posedge clk) disable iff (rst)
		state == TRIPPED ##1 state == RAILS_OFF);

	c_reset_hot: cover property (@(posedge clk)
		rst && hot ##1 !rst && !thermal_trip_n);

	c_reset_cool: cover property (@(posedge clk)
		state == TRIPPED && rst && !hot ##1 state == RUN);

endmodule

/* File: rtl/thermal_trip_pkg.sv */
/*
 * Types of the thermal trip latch.
 * Assumes thermal_trip_cfg.svh for the constants.
 */
package thermal_trip_pkg;

	typedef enum logic [1:0] {
		RUN,
		TRIPPED,
		RAILS_OFF
	} trip_state_e;

	// supply state reported by system power logic
	typedef struct packed {
		logic core_off;
		logic termination_off;
	} rail_status_s;

	// block status seen by system logic
	typedef struct packed {
		logic rails_late;
		logic rails_off;
	} trip_status_s;

endpackage

/* File: verif/power_ctrl_model.sv */
/*
 * System power model: turns both rails off (the core rail alone with one_rail) a set delay after the trip.
 * Assumes it shares clk and rst with the latch.
 */
`timescale 1ns/1ps

module power_ctrl_model
	import thermal_trip_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// trip pin and delay to rails off, in cycles
	input  wire logic       thermal_trip_n,
	input  wire logic [7:0] delay,
	// drop the core rail alone: one rail must not release the trip
	input  wire logic       one_rail,
	// rail status to the latch
	output rail_status_s    rails
);
	logic [7:0] cnt;

	// rails stay off until reset, so no re-power
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt   <= 8'h00;
			rails <= 2'h0;
		end else if (!thermal_trip_n && !rails.core_off) begin
			cnt <= cnt + 8'h01;
			if (cnt == delay) begin
				rails <= one_rail ? 2'h2 : 2'h3;
			end
		end
	end
endmodule

/* File: verif/thermal_trip_latch_tb.sv */
/*
 * Self-checking bench of the thermal trip latch.
 * Assumes the power model file is compiled before it.
 */
`timescale 1ns/1ps

module thermal_trip_latch_tb;
	import thermal_trip_pkg::*;
	logic         clk       = 1'b0;
	logic         rst       = 1'b1;
	logic         over_temp = 1'b0;
	logic [7:0]   delay     = 8'hff;
	logic         one_rail  = 1'b0;
	rail_status_s rails;
	logic         thermal_trip_n;
	logic         exec_halt;
	trip_status_s status;
	int           errors    = 0;
	int           checked   = 0;
	int           cycles    = 0;

	always #12.5 clk = ~clk;

	thermal_trip_latch #(.RAIL_OFF_CYCLES(16), .CNT_W(8)) DUT (
		.clk(clk), .rst(rst), .over_temp(over_temp), .rails(rails),
		.thermal_trip_n(thermal_trip_n), .exec_halt(exec_halt),
		.status(status));

	power_ctrl_model partner (
		.clk(clk), .rst(rst), .thermal_trip_n(thermal_trip_n),
		.delay(delay), .one_rail(one_rail), .rails(rails));

	task automatic check(input string what, input logic seen,
			input logic exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s expected %b seen %b", what, exp, seen);
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask

	task automatic pulse_reset;
		rst = 1'b1;
		step(1);
		rst = 1'b0;
	endtask

	task automatic trip_latency;
		over_temp = 1'b1;
		step(2);
		check("trip_n early", thermal_trip_n, 1'b1);
		step(1);
		check("trip_n", thermal_trip_n, 1'b0);
		check("halt", exec_halt, 1'b1);
		over_temp = 1'b0;
		step(4);
		check("trip_n held", thermal_trip_n, 1'b0);
		check("halt held", exec_halt, 1'b1);
	endtask

	task automatic cool_reset;
		pulse_reset();
		check("trip_n cool", thermal_trip_n, 1'b1);
		check("halt cool", exec_halt, 1'b0);
	endtask

	task automatic hot_reset;
		over_temp = 1'b1;
		step(3);
		pulse_reset();
		check("trip_n hot", thermal_trip_n, 1'b0);
		check("halt hot", exec_halt, 1'b1);
		over_temp = 1'b0;
		step(3);
		pulse_reset();
		check("trip_n cooled", thermal_trip_n, 1'b1);
		check("halt cooled", exec_halt, 1'b0);
	endtask

	task automatic rail_release(input logic [7:0] d, input logic late);
		delay = d;
		over_temp = 1'b1;
		step(3);
		over_temp = 1'b0;
		for (int i = 0; i < 100 && thermal_trip_n !== 1'b1; i++)
			step(1);
		check("trip_n off", thermal_trip_n, 1'b1);
		check("rails_off", status.rails_off, 1'b1);
		check("halt off", exec_halt, 1'b1);
		check("rails_late", status.rails_late, late);
		pulse_reset();
	endtask

	task automatic single_rail;
		one_rail = 1'b1;
		delay = 8'h00;
		over_temp = 1'b1;
		step(3);
		over_temp = 1'b0;
		step(20);
		check("trip_n one rail", thermal_trip_n, 1'b0);
		check("rails_off one rail", status.rails_off, 1'b0);
		check("halt one rail", exec_halt, 1'b1);
		check("rails_late one rail", status.rails_late, 1'b1);
		one_rail = 1'b0;
		pulse_reset();
	endtask

	task automatic final_report;
		if (errors == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			errors++;
			final_report();
		end
	end

	initial begin
		step(6);
		rst = 1'b0;
		trip_latency();
		cool_reset();
		hot_reset();
		rail_release(8'h00, 1'b0);
		rail_release(8'h28, 1'b1);
		single_rail();
		final_report();
	end
endmodule
